// >>> io_timer_skip_exec.sv
/*
 * Execution logic for timer-flag skips, port I/O, indexed port bits,
 * the single-bit port and pull-up control transfers, plus an AXI4-Lite
 * slave for interrupt control and status.
 * Assumes the core presents one instruction per valid cycle on aclk,
 * with the current accumulator and index register alongside it.
 */
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.

module io_timer_skip_exec #(
	parameter int D_WIDTH = 10
) (
	// Clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// Core instruction stream
	input  wire logic                     instr_valid,
	input  wire logic [9:0]               instr,
	input  wire logic [3:0]               acc_in,
	input  wire logic [3:0]               index_in,
	output logic                          acc_wr,
	output logic [3:0]                    acc_wr_data,
	output logic                          skipping,
	// Timer events
	input  wire logic [4:0]               timer_evt,
	// Pins
	input  wire skip_exec_pkg::in_ports_t in_pins,
	output skip_exec_pkg::out_ports_t     out_pins,
	output logic [D_WIDTH-1:0]            port_d,
	output logic                          port_c,
	output logic [3:0]                    pullup_ctrl_0,
	output logic [3:0]                    pullup_ctrl_1,
	// AXI4-Lite slave
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready
);

	if (D_WIDTH < 10 || D_WIDTH > 16) begin : g_bad_width
		$error("D_WIDTH must lie between 10 and 16");
	end

	skip_exec_pkg::exec_state_t state;
	skip_exec_pkg::in_ports_t   in_meta;
	skip_exec_pkg::in_ports_t   in_sync;
	logic [3:0]                 irq_ctrl_reg_one;
	logic [3:0]                 irq_ctrl_reg_two;
	logic [4:0]                 timer_flags;
	logic [4:0]                 enables;
	logic [4:0]                 hit_t;
	logic [4:0]                 skip_t;
	logic                       exec;
	logic                       idx_write_ok;
	logic                       d_bit;
	logic                       skip_d;
	logic                       req_skip;
	logic [7:0]                 aw_addr;
	logic [31:0]                w_data;
	logic                       w_lane0;

	// Pin synchroniser
	always_ff @(posedge aclk) begin
		in_meta <= in_pins;
		in_sync <= in_meta;
	end

	// Skipped words arrive here but never reach exec
	assign exec = instr_valid && (state == skip_exec_pkg::ST_RUN);

	assign enables = {irq_ctrl_reg_two[skip_exec_pkg::EN_T5_POS],
		irq_ctrl_reg_two[skip_exec_pkg::EN_T4_POS],
		irq_ctrl_reg_two[skip_exec_pkg::EN_T3_POS],
		irq_ctrl_reg_one[skip_exec_pkg::EN_T2_POS],
		irq_ctrl_reg_one[skip_exec_pkg::EN_T1_POS]};

	assign hit_t = {instr == skip_exec_pkg::OP_SKIP_T5,
		instr == skip_exec_pkg::OP_SKIP_T4,
		instr == skip_exec_pkg::OP_SKIP_T3,
		instr == skip_exec_pkg::OP_SKIP_T2,
		instr == skip_exec_pkg::OP_SKIP_T1};

	// Enable set turns the test into a no-operation
	assign skip_t = {5{exec}} & hit_t
		& ~enables
		& timer_flags;

	assign idx_write_ok = index_in <= skip_exec_pkg::IDX_MAX_WRITE;
	assign d_bit = (int'(index_in) < D_WIDTH) ? port_d[index_in] : 1'b1;
	// Index 8 and above never skips
	assign skip_d = exec && instr == skip_exec_pkg::OP_SKIP_D_ZERO &&
		index_in <= skip_exec_pkg::IDX_MAX_TEST && !d_bit;
	assign req_skip = (|skip_t) || skip_d;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= skip_exec_pkg::ST_RUN;
		end else begin
			unique case (state)
				skip_exec_pkg::ST_RUN: begin
					if (req_skip) begin
						state <= skip_exec_pkg::ST_SKIP;
					end
				end
				skip_exec_pkg::ST_SKIP: begin
					if (instr_valid) begin
						state <= skip_exec_pkg::ST_RUN;
					end
				end
				default: begin
					state <= skip_exec_pkg::ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			skipping <= 1'b0;
		end else begin
			skipping <= (state == skip_exec_pkg::ST_SKIP) ? !instr_valid
				: req_skip;
		end
	end

	// A new event beats the clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_flags <= 5'h00;
		end else begin
			timer_flags <= (timer_flags & ~skip_t)
				| timer_evt;
		end
	end

	// Accumulator loads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_wr      <= 1'b0;
			acc_wr_data <= skip_exec_pkg::RST_NIBBLE;
		end else begin
			acc_wr <= 1'b0;
			if (exec) begin
				acc_wr <= 1'b1;
				unique case (instr)
					skip_exec_pkg::OP_RD_IN0: acc_wr_data <= in_sync.port0;
					skip_exec_pkg::OP_RD_IN1: acc_wr_data <= in_sync.port1;
					skip_exec_pkg::OP_RD_IN2: acc_wr_data <= in_sync.port2;
					skip_exec_pkg::OP_RD_IN3: acc_wr_data <= in_sync.port3;
					skip_exec_pkg::OP_RD_PULL0: acc_wr_data <= pullup_ctrl_0;
					skip_exec_pkg::OP_RD_PULL1: acc_wr_data <= pullup_ctrl_1;
					default: acc_wr <= 1'b0;
				endcase
			end
		end
	end

	// Output ports and pull-up registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_pins      <= '0;
			pullup_ctrl_0 <= skip_exec_pkg::RST_NIBBLE;
			pullup_ctrl_1 <= skip_exec_pkg::RST_NIBBLE;
			port_c        <= 1'b0;
		end else if (exec) begin
			unique case (instr)
				skip_exec_pkg::OP_WR_OUT0: out_pins.port0 <= acc_in;
				skip_exec_pkg::OP_WR_OUT1: out_pins.port1 <= acc_in;
				skip_exec_pkg::OP_WR_PULL0: pullup_ctrl_0 <= acc_in;
				skip_exec_pkg::OP_WR_PULL1: pullup_ctrl_1 <= acc_in;
				skip_exec_pkg::OP_CLR_C: port_c <= 1'b0;
				skip_exec_pkg::OP_SET_C: port_c <= 1'b1;
				default: ;
			endcase
		end
	end

	// Indexed port; indices beyond 9 are ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_d <= '0;
		end else if (exec) begin
			if (instr == skip_exec_pkg::OP_SET_ALL_D) begin
				port_d <= '1;
			end else if (instr == skip_exec_pkg::OP_CLR_BIT_D && idx_write_ok) begin
				port_d[index_in] <= 1'b0;
			end else if (instr == skip_exec_pkg::OP_SET_BIT_D && idx_write_ok) begin
				port_d[index_in] <= 1'b1;
			end
		end
	end

	// AXI4-Lite write path: address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= skip_exec_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
			end
			if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr == skip_exec_pkg::REG_IRQ_ONE ||
					aw_addr == skip_exec_pkg::REG_IRQ_TWO ||
					aw_addr == skip_exec_pkg::REG_FLAGS ||
					aw_addr == skip_exec_pkg::REG_PORTS) ?
					skip_exec_pkg::RESP_OKAY : skip_exec_pkg::RESP_DECERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data  <= s_axi_wdata;
				w_lane0 <= s_axi_wstrb[0];
			end
		end
	end

	// Enable registers steer the timer tests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ctrl_reg_one <= skip_exec_pkg::RST_NIBBLE;
			irq_ctrl_reg_two <= skip_exec_pkg::RST_NIBBLE;
		end else if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
			w_lane0) begin
			if (aw_addr == skip_exec_pkg::REG_IRQ_ONE) begin
				irq_ctrl_reg_one <= w_data[3:0];
			end
			if (aw_addr == skip_exec_pkg::REG_IRQ_TWO) begin
				irq_ctrl_reg_two <= w_data[3:0];
			end
		end
	end

	// AXI4-Lite read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= skip_exec_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= skip_exec_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				skip_exec_pkg::REG_IRQ_ONE:
					s_axi_rdata <= {28'h0, irq_ctrl_reg_one};
				skip_exec_pkg::REG_IRQ_TWO:
					s_axi_rdata <= {28'h0, irq_ctrl_reg_two};
				skip_exec_pkg::REG_FLAGS:
					s_axi_rdata <= {27'h0, timer_flags};
				skip_exec_pkg::REG_PORTS:
					s_axi_rdata <= {15'h0, port_c, 16'(port_d)};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= skip_exec_pkg::RESP_DECERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	t1_skip_a: assert property (skip_t[0] |=> skipping &&
		timer_flags[0] == $past(timer_evt[0]))
		else $error("timer-1 skip did not skip and clear");
	t2_skip_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_T2 &&
		!irq_ctrl_reg_one[3] && timer_flags[1] && !timer_evt[1]
		|=> skipping && !timer_flags[1])
		else $error("timer-2 skip did not skip and clear");
	t3_skip_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_T3 &&
		!irq_ctrl_reg_two[0] && timer_flags[2] |=> skipping)
		else $error("timer-3 skip missing");
	t4_skip_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_T4 &&
		!irq_ctrl_reg_two[3] && timer_flags[3] |=> skipping)
		else $error("timer-4 skip missing");
	t5_skip_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_T5 &&
		!irq_ctrl_reg_two[1] && timer_flags[4] |=> skipping)
		else $error("timer-5 skip missing");
	timer_nop_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_T1 && irq_ctrl_reg_one[2] &&
		!timer_evt[0] |=> !skipping && $stable(timer_flags[0]))
		else $error("enabled timer test was not a no-operation");
	in0_load_a: assert property (exec &&
		instr == skip_exec_pkg::OP_RD_IN0
		|=> acc_wr && acc_wr_data == $past(in_sync.port0))
		else $error("port 0 input not loaded");
	out0_wr_a: assert property (exec &&
		instr == skip_exec_pkg::OP_WR_OUT0
		|=> out_pins.port0 == $past(acc_in))
		else $error("port 0 output not written");
	d_all_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SET_ALL_D |=> &port_d)
		else $error("indexed port not set in full");
	d_clr_a: assert property (exec &&
		instr == skip_exec_pkg::OP_CLR_BIT_D && idx_write_ok
		|=> !port_d[$past(index_in)])
		else $error("indexed bit not cleared");
	d_set_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SET_BIT_D && idx_write_ok
		|=> port_d[$past(index_in)])
		else $error("indexed bit not set");
	d_test_a: assert property (exec &&
		instr == skip_exec_pkg::OP_SKIP_D_ZERO &&
		index_in <= skip_exec_pkg::IDX_MAX_TEST
		|=> skipping == !$past(d_bit))
		else $error("indexed bit test skipped wrongly");
	c_clear_a: assert property (exec &&
		instr == skip_exec_pkg::OP_CLR_C |=> !port_c)
		else $error("single-bit port not cleared");
	pu1_wr_a: assert property (exec &&
		instr == skip_exec_pkg::OP_WR_PULL1
		|=> pullup_ctrl_1 == $past(acc_in))
		else $error("pull-up register one not written");
	skip_quiet_a: assert property (state == skip_exec_pkg::ST_SKIP &&
		instr_valid |=> state == skip_exec_pkg::ST_RUN && !acc_wr &&
		$stable(port_d) && $stable(out_pins) && $stable(port_c))
		else $error("skipped instruction had an effect");

	t1_skip_c: cover property (skip_t[0] ##1 instr_valid);
	d_skip_c:  cover property (skip_d ##1 instr_valid);
	evt_win_c: cover property (skip_t[0] && timer_evt[0]);
	axi_wr_c:  cover property (s_axi_bvalid && s_axi_bready);

endmodule // io_timer_skip_exec

// >>> skip_exec_pkg.sv
/*
 * Shared constants and carriers for the I/O and timer-skip execution block.
 * Assumes a 10-bit instruction word and a 4-bit accumulator.
 */
package skip_exec_pkg;

	// Opcodes
	localparam logic [9:0] OP_SKIP_T1     = 10'h280;
	localparam logic [9:0] OP_SKIP_T2     = 10'h281;
	localparam logic [9:0] OP_SKIP_T3     = 10'h282;
	localparam logic [9:0] OP_SKIP_T4     = 10'h283;
	localparam logic [9:0] OP_SKIP_T5     = 10'h284;
	localparam logic [9:0] OP_RD_IN0      = 10'h260;
	localparam logic [9:0] OP_RD_IN1      = 10'h261;
	localparam logic [9:0] OP_RD_IN2      = 10'h262;
	localparam logic [9:0] OP_RD_IN3      = 10'h263;
	localparam logic [9:0] OP_WR_OUT0     = 10'h220;
	localparam logic [9:0] OP_WR_OUT1     = 10'h221;
	localparam logic [9:0] OP_SET_ALL_D   = 10'h011;
	localparam logic [9:0] OP_CLR_BIT_D   = 10'h014;
	localparam logic [9:0] OP_SET_BIT_D   = 10'h015;
	localparam logic [9:0] OP_SKIP_D_ZERO = 10'h024;
	localparam logic [9:0] OP_CLR_C       = 10'h28c;
	localparam logic [9:0] OP_SET_C       = 10'h28d;
	localparam logic [9:0] OP_RD_PULL0    = 10'h257;
	localparam logic [9:0] OP_WR_PULL0    = 10'h22d;
	localparam logic [9:0] OP_RD_PULL1    = 10'h25e;
	localparam logic [9:0] OP_WR_PULL1    = 10'h22e;

	// Enable bit positions in the two interrupt control registers
	localparam int EN_T1_POS = 2;
	localparam int EN_T2_POS = 3;
	localparam int EN_T3_POS = 0;
	localparam int EN_T4_POS = 3;
	localparam int EN_T5_POS = 1;

	// Index limits
	localparam logic [3:0] IDX_MAX_WRITE = 4'h9;
	localparam logic [3:0] IDX_MAX_TEST  = 4'h7;

	// Register byte addresses
	localparam logic [7:0] REG_IRQ_ONE = 8'h00;
	localparam logic [7:0] REG_IRQ_TWO = 8'h04;
	localparam logic [7:0] REG_FLAGS   = 8'h08;
	localparam logic [7:0] REG_PORTS   = 8'h0c;

	// Reset value and AXI response codes
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_SKIP = 2'b10
	} exec_state_t;

	typedef struct packed {
		logic [3:0] port3;
		logic [3:0] port2;
		logic [3:0] port1;
		logic [3:0] port0;
	} in_ports_t;

	typedef struct packed {
		logic [3:0] port1;
		logic [3:0] port0;
	} out_ports_t;

endpackage

// >>> io_and_timer_skip_exec_bench.sv
/*
 * Self-checking bench for the I/O and timer-skip execution block.
 * Assumes the package and design files are compiled first; the bench
 * drives the instruction stream, pins and the AXI4-Lite slave itself.
 */
module io_and_timer_skip_exec_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic                      aclk;
	logic                      aresetn;
	logic                      instr_valid;
	logic [9:0]                instr;
	logic [3:0]                acc_in;
	logic [3:0]                index_in;
	logic                      acc_wr;
	logic [3:0]                acc_wr_data;
	logic                      skipping;
	logic [4:0]                timer_evt;
	skip_exec_pkg::in_ports_t  in_pins;
	skip_exec_pkg::out_ports_t out_pins;
	logic [9:0]                port_d;
	logic                      port_c;
	logic [3:0]                pullup_ctrl_0;
	logic [3:0]                pullup_ctrl_1;
	logic [7:0]                s_axi_awaddr;
	logic                      s_axi_awvalid;
	logic                      s_axi_awready;
	logic [31:0]               s_axi_wdata;
	logic [3:0]                s_axi_wstrb;
	logic                      s_axi_wvalid;
	logic                      s_axi_wready;
	logic [1:0]                s_axi_bresp;
	logic                      s_axi_bvalid;
	logic                      s_axi_bready;
	logic [7:0]                s_axi_araddr;
	logic                      s_axi_arvalid;
	logic                      s_axi_arready;
	logic [31:0]               s_axi_rdata;
	logic [1:0]                s_axi_rresp;
	logic                      s_axi_rvalid;
	logic                      s_axi_rready;
	int                        n_errors;
	int                        cmp_count;
	int                        cycles;
	logic [31:0]               rd;
	logic [1:0]                resp;

	io_timer_skip_exec #(
		.D_WIDTH(10)
	) u_io_timer_skip_exec (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.instr_valid   (instr_valid),
		.instr         (instr),
		.acc_in        (acc_in),
		.index_in      (index_in),
		.acc_wr        (acc_wr),
		.acc_wr_data   (acc_wr_data),
		.skipping      (skipping),
		.timer_evt     (timer_evt),
		.in_pins       (in_pins),
		.out_pins      (out_pins),
		.port_d        (port_d),
		.port_c        (port_c),
		.pullup_ctrl_0 (pullup_ctrl_0),
		.pullup_ctrl_1 (pullup_ctrl_1),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		logic b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b_done) begin
			@(posedge aclk);
			if (aw_done && w_done && s_axi_bvalid) begin
				resp = s_axi_bresp;
				s_axi_bready <= 1'b0;
				b_done = 1'b1;
			end
			if (!aw_done && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a);
		logic ar_done;
		logic r_done;
		ar_done = 1'b0;
		r_done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r_done) begin
			@(posedge aclk);
			if (ar_done && s_axi_rvalid) begin
				rd = s_axi_rdata;
				resp = s_axi_rresp;
				s_axi_rready <= 1'b0;
				r_done = 1'b1;
			end
			if (!ar_done && s_axi_arready) begin
				ar_done = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end
	endtask

	// One instruction word; returns just after its taking edge
	task automatic exec(input logic [9:0] op, input logic [3:0] a,
			input logic [3:0] y);
		@(posedge aclk);
		instr <= op;
		acc_in <= a;
		index_in <= y;
		instr_valid <= 1'b1;
		@(posedge aclk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic t_reset_regs();
		check({port_d, port_c, skipping, acc_wr}, 32'h0);
		check({out_pins, pullup_ctrl_0, pullup_ctrl_1}, 32'h0);
		for (int i = 0; i < 4; i++) begin
			axi_rd(8'(i * 4));
			check({30'h0, resp}, 32'h0);
			check(rd, 32'h0);
		end
		axi_rd(8'h10);
		check({30'h0, resp}, 32'h3);
		axi_wr(8'h10, 32'hf);
		check({30'h0, resp}, 32'h3);
		axi_wr(skip_exec_pkg::REG_IRQ_ONE, 32'hff);
		axi_rd(skip_exec_pkg::REG_IRQ_ONE);
		check(rd, 32'hf);
		// Lane 0 off: the write is answered but leaves the register alone
		s_axi_wstrb <= 4'he;
		axi_wr(skip_exec_pkg::REG_IRQ_ONE, 32'h0);
		check({30'h0, resp}, 32'h0);
		s_axi_wstrb <= 4'hf;
		axi_rd(skip_exec_pkg::REG_IRQ_ONE);
		check(rd, 32'hf);
		$display("test reset_regs done");
	endtask

	task automatic t_timer();
		int pos [5] = '{skip_exec_pkg::EN_T1_POS, skip_exec_pkg::EN_T2_POS,
			skip_exec_pkg::EN_T3_POS, skip_exec_pkg::EN_T4_POS,
			skip_exec_pkg::EN_T5_POS};
		for (int i = 0; i < 5; i++) begin
			for (int en = 0; en < 2; en++) begin
				@(posedge aclk);
				timer_evt <= 5'h01 << i;
				@(posedge aclk);
				timer_evt <= 5'h00;
				axi_wr((i < 2) ? skip_exec_pkg::REG_IRQ_ONE
					: skip_exec_pkg::REG_IRQ_TWO, 32'(en) << pos[i]);
				exec(10'(skip_exec_pkg::OP_SKIP_T1 + i), 4'h0, 4'h0);
				check(skipping, 32'(en == 0));
				axi_rd(skip_exec_pkg::REG_FLAGS);
				check(rd[i], 32'(en));
				exec(skip_exec_pkg::OP_SET_C, 4'h0, 4'h0);
				check({acc_wr, port_c}, 32'(en));
				check(skipping, 32'h0);
				exec(skip_exec_pkg::OP_CLR_C, 4'h0, 4'h0);
				check(port_c, 32'h0);
			end
		end
		$display("test timer done");
	endtask

	task automatic t_ports();
		logic [9:0] rd_op [4] = '{skip_exec_pkg::OP_RD_IN0,
			skip_exec_pkg::OP_RD_IN1, skip_exec_pkg::OP_RD_IN2,
			skip_exec_pkg::OP_RD_IN3};
		@(posedge aclk);
		in_pins <= 16'h3c5a;
		repeat (3) @(posedge aclk);
		for (int i = 0; i < 4; i++) begin
			exec(rd_op[i], 4'h0, 4'h0);
			check({acc_wr, acc_wr_data},
				{27'h0, 1'b1, 4'(16'h3c5a >> (4 * i))});
		end
		exec(skip_exec_pkg::OP_WR_OUT0, 4'h9, 4'h0);
		check({acc_wr, out_pins.port0}, 32'h9);
		exec(skip_exec_pkg::OP_WR_OUT1, 4'h6, 4'h0);
		check(out_pins, 32'h69);
		exec(skip_exec_pkg::OP_SET_C, 4'h0, 4'h0);
		check(port_c, 32'h1);
		$display("test ports done");
	endtask

	task automatic t_port_d();
		exec(skip_exec_pkg::OP_SET_ALL_D, 4'h0, 4'h0);
		check(port_d, 32'h3ff);
		exec(skip_exec_pkg::OP_CLR_BIT_D, 4'h0, 4'h9);
		check(port_d, 32'h1ff);
		exec(skip_exec_pkg::OP_CLR_BIT_D, 4'h0, 4'ha);
		check(port_d, 32'h1ff);
		exec(skip_exec_pkg::OP_CLR_BIT_D, 4'h0, 4'h0);
		check(port_d, 32'h1fe);
		exec(skip_exec_pkg::OP_SKIP_D_ZERO, 4'h0, 4'h0);
		check(skipping, 32'h1);
		exec(skip_exec_pkg::OP_CLR_C, 4'h0, 4'h0);
		check(port_c, 32'h1);
		exec(skip_exec_pkg::OP_SKIP_D_ZERO, 4'h0, 4'h9);
		check(skipping, 32'h0);
		exec(skip_exec_pkg::OP_SKIP_D_ZERO, 4'h0, 4'h1);
		check(skipping, 32'h0);
		exec(skip_exec_pkg::OP_SET_BIT_D, 4'h0, 4'h9);
		check(port_d, 32'h3fe);
		exec(skip_exec_pkg::OP_SET_BIT_D, 4'h0, 4'h0);
		check(port_d, 32'h3ff);
		$display("test port_d done");
	endtask

	task automatic t_pullup();
		exec(skip_exec_pkg::OP_WR_PULL0, 4'hb, 4'h0);
		check(pullup_ctrl_0, 32'hb);
		exec(skip_exec_pkg::OP_WR_PULL1, 4'h4, 4'h0);
		check({pullup_ctrl_1, pullup_ctrl_0}, 32'h4b);
		exec(skip_exec_pkg::OP_RD_PULL0, 4'h0, 4'h0);
		check({acc_wr, acc_wr_data}, 32'h1b);
		exec(skip_exec_pkg::OP_RD_PULL1, 4'h0, 4'h0);
		check({acc_wr, acc_wr_data}, 32'h14);
		$display("test pullup done");
	endtask

	initial begin
		{aresetn, instr_valid, instr, acc_in, index_in, timer_evt} = '0;
		in_pins = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		{n_errors, cmp_count, cycles, rd, resp} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		t_reset_regs();
		t_timer();
		t_ports();
		t_port_d();
		t_pullup();
		finish_test();
	end
endmodule // io_and_timer_skip_exec_bench
